// ===== design/afr_pkg.sv
package afr_pkg;

    // ------------------------------------------------------------------
    // register map (byte-wide i/o offsets)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W       = 5;
    localparam logic [4:0]  OFS_START    = 5'h03;
    localparam logic [4:0]  OFS_CLEAR    = 5'h08;
    localparam logic [4:0]  OFS_FIFO     = 5'h0A;  // read side
    localparam logic [4:0]  OFS_TC_CLEAR = 5'h0A;  // write side

    // ------------------------------------------------------------------
    // data widths and depths
    // ------------------------------------------------------------------
    localparam int unsigned RAW_W      = 12;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned EXT_W      = 4;        // extension bits
    localparam int unsigned SIGN_BIT   = 11;
    localparam int unsigned FIFO_DEPTH = 512;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RDATA_RST  = 8'h00;
    // synchroniser idle levels: bit0 counter a0, bit1 ext pin, bit2 tc
    localparam logic [2:0]  SYNC_RST   = 3'h3;
    localparam int unsigned SRC_A0     = 0;
    localparam int unsigned SRC_EXT    = 1;
    localparam int unsigned SRC_TC     = 2;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [BYTE_W-1:0] high;
        logic [BYTE_W-1:0] low;
    } afr_word_t;

    typedef enum logic [0:0] {
        BYTE_LOW  = 1'b0,
        BYTE_HIGH = 1'b1
    } afr_byte_sel_t;

    // widen a raw conversion result to a stored word
    function automatic afr_word_t afr_extend(input logic [RAW_W-1:0] raw,
                                             input logic signed_sel);
        afr_word_t w;
        w = {{EXT_W{signed_sel & raw[SIGN_BIT]}}, raw};
        return w;
    endfunction

endpackage

// ===== design/afr_fifo.sv
`timescale 1ns/1ps
module afr_fifo
    import afr_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      push_i,
    input  wire afr_word_t data_i,
    input  wire logic      pop_i,
    input  wire logic      flush_i,
    output afr_word_t      head_o,
    output logic [AW:0]    count_o,
    output logic           full_o,
    output logic           empty_o
);

    // ------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------
    afr_word_t       mem [DEPTH];
    logic [AW-1:0]   wptr;
    logic [AW-1:0]   rptr;
    logic [AW:0]     count;
    logic [AW-1:0]   next_wptr;
    logic [AW-1:0]   next_rptr;
    logic [AW:0]     next_count;
    logic            we;
    logic [AW-1:0]   widx;
    logic            do_push;
    logic            do_pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("afr_fifo: depth must be a power of two, at least 2");
        end
    end

    assign full_o  = (count == DEPTH[AW:0]);
    assign empty_o = (count == '0);
    assign count_o = count;
    assign head_o  = mem[rptr];

    // flush restarts the queue; a push in the same cycle becomes entry 0
    always_comb begin
        do_push    = push_i & ~full_o;
        do_pop     = pop_i & ~empty_o;
        we         = push_i & (flush_i | ~full_o);
        widx       = flush_i ? '0 : wptr;
        next_wptr  = wptr;
        next_rptr  = rptr;
        next_count = count;
        if (flush_i) begin
            next_rptr  = '0;
            next_wptr  = push_i ? AW'(1) : '0;
            next_count = push_i ? (AW+1)'(1) : '0;
        end else begin
            if (do_push) begin
                next_wptr = wptr + AW'(1);
            end
            if (do_pop) begin
                next_rptr = rptr + AW'(1);
            end
            next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // pointer registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
    end

    // entry storage, written by index
    always_ff @(posedge clk_i) begin
        if (we) begin
            mem[widx] <= data_i;
        end
    end

endmodule

// ===== design/afr_readout.sv
// What this block does
// - widen 12-bit results to 16 bits, zero or sign fill; 512-entry queue
// - two byte reads return one word, low byte first then high byte
// - a word leaves the queue once read; all read means empty
// - result-present flag is high while the queue holds a word, one clock later
// - reading an empty queue gives junk and changes nothing
// - signed-format select chooses zero fill or sign fill
// - clear write resets converter, empties queue, reloads last result
// - clear write also clears all error flags
// - any write to start location begins one conversion
// - falling pulse on counter a0 or external pin begins a conversion
// - terminal-count pulse raises request; a write to the fifo location drops it
// - inhibit bit or pin driven outward blocks external pin pulses
`timescale 1ns/1ps
module afr_readout #(
    parameter int unsigned DEPTH = afr_pkg::FIFO_DEPTH
) (
    input  wire logic                           MCLK_I,
    input  wire logic                           RST_I,
    input  wire logic [afr_pkg::ADDR_W-1:0]     ADDR_I,
    input  wire logic                           READ_STROBE_I,
    input  wire logic                           WRITE_STROBE_I,
    output logic      [afr_pkg::BYTE_W-1:0]     RDATA_O,
    input  wire logic                           SIGNED_FORMAT_SELECT_I,
    input  wire logic                           EXTERNAL_CONVERT_INHIBIT_I,
    input  wire logic                           CONVERT_PIN_DRIVE_I,
    input  wire logic                           COUNTER_A0_N_I,
    input  wire logic                           EXTERNAL_CONVERT_N_I,
    input  wire logic                           TRANSFER_COUNT_DONE_I,
    input  wire logic                           CONV_DONE_I,
    input  wire logic [afr_pkg::RAW_W-1:0]      CONV_DATA_I,
    output logic                                CONV_START_O,
    output logic                                ADC_RESET_O,
    output logic                                RESULT_PRESENT_FLAG_O,
    output logic                                OVERFLOW_ERROR_O,
    output logic                                TC_IRQ_O
);
    import afr_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------------
    logic [2:0]      sync1;
    logic [2:0]      sync2;
    logic [2:0]      sync3;
    afr_byte_sel_t   byte_sel;
    afr_byte_sel_t   next_byte_sel;
    afr_word_t       last_word;
    afr_word_t       next_last_word;
    afr_word_t       push_word;
    afr_word_t       head;
    logic [AW:0]     count;
    logic            full;
    logic            empty;
    logic            fifo_rd;
    logic            start_wr;
    logic            clear_wr;
    logic            tc_clear_wr;
    logic            pop;
    logic            push;
    logic            a0_fall;
    logic            ext_fall;
    logic            tc_rise;
    logic            ovf_event;
    logic [7:0]      next_rdata;
    logic            next_start;
    logic            next_ovf;
    logic            next_irq;

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------

    // two flops per pin, a third holds the previous level
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
            sync3 <= SYNC_RST;
        end else begin
            sync1 <= {TRANSFER_COUNT_DONE_I, EXTERNAL_CONVERT_N_I,
                      COUNTER_A0_N_I};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign a0_fall  = sync3[SRC_A0] & ~sync2[SRC_A0];
    assign ext_fall = sync3[SRC_EXT] & ~sync2[SRC_EXT];
    assign tc_rise  = ~sync3[SRC_TC] & sync2[SRC_TC];

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign fifo_rd     = READ_STROBE_I & (ADDR_I == OFS_FIFO);
    assign start_wr    = WRITE_STROBE_I & (ADDR_I == OFS_START);
    assign clear_wr    = WRITE_STROBE_I & (ADDR_I == OFS_CLEAR);
    assign tc_clear_wr = WRITE_STROBE_I & (ADDR_I == OFS_TC_CLEAR);

    // ------------------------------------------------------------------
    // result queue
    // ------------------------------------------------------------------

    // widen incoming result; clear reloads newest known value
    always_comb begin
        push_word      = afr_extend(CONV_DATA_I,
                                    SIGNED_FORMAT_SELECT_I);
        next_last_word = CONV_DONE_I ? push_word : last_word;
        push           = clear_wr | CONV_DONE_I;
        pop            = fifo_rd & (byte_sel == BYTE_HIGH) & ~empty
                         & ~clear_wr;
        ovf_event      = CONV_DONE_I & full & ~clear_wr;
    end

    afr_fifo #(
        .DEPTH   (DEPTH)
    ) u_fifo (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .push_i  (push),
        .data_i  (next_last_word),
        .pop_i   (pop),
        .flush_i (clear_wr),
        .head_o  (head),
        .count_o (count),
        .full_o  (full),
        .empty_o (empty)
    );

    // ------------------------------------------------------------------
    // byte readout and control outputs
    // ------------------------------------------------------------------

    // next values of readout, flags and strobes
    always_comb begin
        next_byte_sel = byte_sel;
        next_rdata    = RDATA_O;
        if (clear_wr) begin
            next_byte_sel = BYTE_LOW;
        end else if (fifo_rd) begin
            case (byte_sel)
                BYTE_LOW: begin
                    next_rdata = head.low;
                    if (!empty) begin
                        next_byte_sel = BYTE_HIGH;
                    end
                end
                BYTE_HIGH: begin
                    next_rdata    = head.high;
                    next_byte_sel = BYTE_LOW;
                end
                default: begin
                    next_byte_sel = BYTE_LOW;
                end
            endcase
        end
        next_start = start_wr
                     | a0_fall
                     | (ext_fall & ~EXTERNAL_CONVERT_INHIBIT_I
                        & ~CONVERT_PIN_DRIVE_I);
        next_ovf   = clear_wr ? 1'b0
                     : (OVERFLOW_ERROR_O | ovf_event);
        next_irq   = tc_rise | (TC_IRQ_O & ~tc_clear_wr);
    end

    // register all outputs
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            byte_sel              <= BYTE_LOW;
            last_word             <= '0;
            RDATA_O               <= RDATA_RST;
            CONV_START_O          <= 1'b0;
            ADC_RESET_O           <= 1'b0;
            RESULT_PRESENT_FLAG_O <= 1'b0;
            OVERFLOW_ERROR_O      <= 1'b0;
            TC_IRQ_O              <= 1'b0;
        end else begin
            byte_sel              <= next_byte_sel;
            last_word             <= next_last_word;
            RDATA_O               <= next_rdata;
            CONV_START_O          <= next_start;
            ADC_RESET_O           <= clear_wr;
            RESULT_PRESENT_FLAG_O <= ~empty;
            OVERFLOW_ERROR_O      <= next_ovf;
            TC_IRQ_O              <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    sequence low_read_s;
        fifo_rd && !clear_wr && !empty && byte_sel == BYTE_LOW;
    endsequence

    sequence high_read_s;
        fifo_rd && !clear_wr && !CONV_DONE_I && byte_sel == BYTE_HIGH;
    endsequence

    low_byte_first_a: assert property (
        low_read_s |=> RDATA_O == $past(head.low) && byte_sel == BYTE_HIGH)
        else $error("first fifo read did not give low byte");

    pair_pop_a: assert property (
        low_read_s ##1 high_read_s |=>
            count == $past(count) - (AW+1)'(1) && byte_sel == BYTE_LOW)
        else $error("word not removed after high byte read");

    present_flag_a: assert property (
        ##1 RESULT_PRESENT_FLAG_O == ($past(count) != '0))
        else $error("result present flag disagrees with queue");

    empty_read_a: assert property (
        fifo_rd && empty && !push |=> count == '0 && byte_sel == BYTE_LOW)
        else $error("read of empty queue changed state");

    fill_bits_a: assert property (
        CONV_DONE_I |-> push_word.high[BYTE_W-1 -: EXT_W] ==
            (SIGNED_FORMAT_SELECT_I ? {EXT_W{CONV_DATA_I[SIGN_BIT]}}
                                    : {EXT_W{1'b0}}))
        else $error("extension bits wrong for chosen format");

    clear_reload_a: assert property (
        clear_wr |=> count == (AW+1)'(1) && ADC_RESET_O
            && !OVERFLOW_ERROR_O ##1 (ADC_RESET_O == $past(clear_wr)))
        else $error("clear did not leave exactly one word");

    start_soft_a: assert property (
        start_wr |=> CONV_START_O)
        else $error("start write gave no conversion start");

    ext_inhibit_a: assert property (
        !start_wr && !a0_fall && (EXTERNAL_CONVERT_INHIBIT_I
            || CONVERT_PIN_DRIVE_I) |=> !CONV_START_O)
        else $error("blocked external pulse started a conversion");

    tc_irq_a: assert property (
        tc_rise |=> TC_IRQ_O ##1 (TC_IRQ_O || $past(tc_clear_wr)))
        else $error("terminal count request not raised or held");

    overflow_a: assert property (
        CONV_DONE_I && full && !clear_wr && !pop |=>
            OVERFLOW_ERROR_O && count == $past(count))
        else $error("full queue accepted a result or missed overflow");

endmodule

// ===== sim/afr_conv_model.sv
`timescale 1ns/1ps
module afr_conv_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        reset_i,
    input  wire logic [11:0] value_i,
    input  wire logic [3:0]  delay_i,
    output logic             done_o,
    output logic [11:0]      data_o
);
    logic [4:0] wait_cnt;

    // counts the conversion time, then shows the result for one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= 5'h00;
            done_o   <= 1'b0;
            data_o   <= 12'hFFF;
        end else begin
            done_o <= 1'b0;
            data_o <= ~data_o; // result lines carry no value outside done
            if (reset_i) begin
                wait_cnt <= 5'h00;
            end else if (start_i && wait_cnt == 5'h00) begin
                wait_cnt <= {1'b0, delay_i} + 5'h01;
            end else if (wait_cnt == 5'h01) begin
                done_o   <= 1'b1;
                data_o   <= value_i;
                wait_cnt <= 5'h00;
            end else if (wait_cnt != 5'h00) begin
                wait_cnt <= wait_cnt - 5'h01;
            end
        end
    end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
    import afr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic        rd_stb = 1'b0;
    logic        wr_stb = 1'b0;
    logic [7:0]  rdata;
    logic        fmt = 1'b0;
    logic        inhibit = 1'b0;
    logic        drive = 1'b0;
    logic        a0_n = 1'b1;
    logic        ext_n = 1'b1;
    logic        tc = 1'b0;
    logic        conv_done;
    logic [11:0] conv_data;
    logic [11:0] conv_value = 12'h000;
    logic        conv_start;
    logic        adc_reset;
    logic        flag;
    logic        ovf;
    logic        irq;
    logic        got;
    logic [7:0]  rdata_dummy;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [11:0] vals [4] = '{12'hABC, 12'h8C3, 12'h7FF, 12'h800};
    logic        sgns [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    // ------------------------------------------------------------------
    // clock, design and converter
    // ------------------------------------------------------------------
    always #20 mclk = ~mclk;

    afr_readout #(.DEPTH(8)) u_dut (
        .MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .READ_STROBE_I(rd_stb),
        .WRITE_STROBE_I(wr_stb), .RDATA_O(rdata),
        .SIGNED_FORMAT_SELECT_I(fmt), .EXTERNAL_CONVERT_INHIBIT_I(inhibit),
        .CONVERT_PIN_DRIVE_I(drive), .COUNTER_A0_N_I(a0_n),
        .EXTERNAL_CONVERT_N_I(ext_n), .TRANSFER_COUNT_DONE_I(tc),
        .CONV_DONE_I(conv_done), .CONV_DATA_I(conv_data),
        .CONV_START_O(conv_start), .ADC_RESET_O(adc_reset),
        .RESULT_PRESENT_FLAG_O(flag), .OVERFLOW_ERROR_O(ovf),
        .TC_IRQ_O(irq));

    afr_conv_model u_conv (
        .clk_i(mclk), .rst_i(rst), .start_i(conv_start), .reset_i(adc_reset),
        .value_i(conv_value), .delay_i(4'h4), .done_o(conv_done),
        .data_o(conv_data));

    // ------------------------------------------------------------------
    // host access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a);
        @(posedge mclk);
        addr   <= a;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(output logic [7:0] d);
        @(posedge mclk);
        addr   <= OFS_FIFO;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask

    task automatic rd_word(input logic [15:0] exp);
        logic [7:0] b;
        @(negedge mclk);
        check(flag, 1'b1);
        rd(b);
        check(b, exp[7:0]);
        rd(b);
        check(b, exp[15:8]);
    endtask

    task automatic wait_done(input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge mclk);
            seen = conv_done;
        end
    endtask

    // software start, then wait for the result to land in the queue
    task automatic convert(input logic [11:0] v);
        logic ok;
        conv_value = v;
        wr(OFS_START);
        wait_done(30, ok);
        check(ok, 1'b1);
        repeat (3) @(negedge mclk);
    endtask

    task automatic pin_pulse(input logic ext);
        @(posedge mclk);
        if (ext) begin
            ext_n <= 1'b0;
        end else begin
            a0_n <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        a0_n  <= 1'b1;
        ext_n <= 1'b1;
    endtask

    task automatic print_verdict;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check(flag, 1'b0);
        // counter output already high, so clear before software starts
        wr(OFS_CLEAR);
        @(negedge mclk);
        check(adc_reset, 1'b1);
        @(negedge mclk);
        check(flag, 1'b1);
        rd_word(16'h0000);
        repeat (2) @(negedge mclk);
        check(flag, 1'b0);
        // zero fill on the unsigned format, sign fill on the signed one
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            fmt <= sgns[k];
            convert(vals[k]);
            rd_word({{4{sgns[k] & vals[k][11]}}, vals[k]});
        end
        @(posedge mclk);
        fmt <= 1'b0;
        // empty read neither pops nor shifts byte pairing
        rd(rdata_dummy);
        repeat (2) @(negedge mclk);
        check(flag, 1'b0);
        convert(12'h123);
        rd_word(16'h0123);
        // fill past the depth, drain in order
        for (int i = 0; i < 9; i++) begin
            convert(12'h100 + 12'(i));
        end
        check(ovf, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rd_word(16'h0100 + 16'(i));
        end
        repeat (2) @(negedge mclk);
        check(flag, 1'b0);
        check(ovf, 1'b1);
        wr(OFS_CLEAR);
        @(negedge mclk);
        check(ovf, 1'b0);
        rd_word(16'h0108);
        // hardware starts from the counter and the external pin
        conv_value = 12'h055;
        pin_pulse(1'b0);
        wait_done(20, got);
        check(got, 1'b1);
        repeat (3) @(negedge mclk);
        rd_word(16'h0055);
        @(posedge mclk);
        inhibit <= 1'b1;
        pin_pulse(1'b1);
        wait_done(20, got);
        check(got, 1'b0);
        @(posedge mclk);
        inhibit <= 1'b0;
        drive   <= 1'b1;
        pin_pulse(1'b1);
        wait_done(20, got);
        check(got, 1'b0);
        @(posedge mclk);
        drive <= 1'b0;
        pin_pulse(1'b1);
        wait_done(20, got);
        check(got, 1'b1);
        repeat (3) @(negedge mclk);
        rd_word(16'h0055);
        // terminal count raises the request, its clear write drops it
        @(posedge mclk);
        tc <= 1'b1;
        repeat (2) @(posedge mclk);
        tc <= 1'b0;
        repeat (6) @(negedge mclk);
        check(irq, 1'b1);
        wr(OFS_TC_CLEAR);
        @(negedge mclk);
        check(irq, 1'b0);
        check(flag, 1'b0);
        print_verdict();
    end

    // watchdog against a hung handshake
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
endmodule
